// [src/acmp_pkg.sv]
// Shared constants of the analog comparator control block.
// Assumes a 32-bit AHB-Lite register bus with one aligned word per register.
package acmp_pkg;

  // Register byte offsets.
  localparam logic [7:0] OFF_CTRL1 = 8'h00;
  localparam logic [7:0] OFF_CTRL2 = 8'h04;
  localparam logic [7:0] OFF_CTRL3 = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0c;
  localparam logic [7:0] OFF_FLAG2 = 8'h10;
  localparam logic [7:0] OFF_FLAG5 = 8'h14;
  localparam logic [7:0] OFF_ENA2 = 8'h18;
  localparam logic [7:0] OFF_ENA5 = 8'h1c;
  localparam logic [7:0] OFF_INTCTL = 8'h20;

  // Control register fields.
  localparam int ON_BIT = 7;
  localparam int OE_BIT = 6;
  localparam int POL_BIT = 5;
  localparam int EDGE_HI = 4;
  localparam int EDGE_LO = 3;
  localparam int REF_BIT = 2;
  localparam int CH_HI = 1;
  localparam int CH_LO = 0;

  // Edge selection codes.
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_ANY = 2'h3;

  // Inverting input selection codes.
  localparam logic [1:0] CH_B = 2'h0;
  localparam logic [1:0] CH_C = 2'h1;
  localparam logic [1:0] CH_D = 2'h2;
  localparam logic [1:0] CH_FIXED = 2'h3;

  // Interrupt flag and enable positions.
  localparam int CMP1_IRQ_BIT = 5;
  localparam int CMP2_IRQ_BIT = 6;
  localparam int CMP3_IRQ_BIT = 5;
  localparam int PERIPH_EN_BIT = 6;
  localparam int GLOBAL_EN_BIT = 7;

  // Reset values.
  localparam logic [7:0] CTRL_RESET = 8'h1f;
  localparam logic STATUS_RESET = 1'h1;

endpackage

// [src/cmp_channel.sv]
// One comparator channel: input selection, decision, polarity and edge event.
// Assumes analog levels arrive as unsigned codes synchronous to clk.
`timescale 1ns/1ns
module cmp_channel #(
  parameter int W = 10
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Control byte of this channel.
  input wire logic [7:0] ctrl,
  // Analog levels.
  input wire logic [W-1:0] pinA,
  input wire logic [W-1:0] pinB,
  input wire logic [W-1:0] pinC,
  input wire logic [W-1:0] pinD,
  input wire logic [W-1:0] ladderRef,
  input wire logic [W-1:0] fixedRef,
  // Results.
  output logic coutQ,
  output logic evtQ
);

  typedef struct packed {
    logic cout;
    logic evt;
  } chan_s;

  chan_s state_q;
  chan_s state_d;
  logic [W-1:0] plusLvl;
  logic [W-1:0] minusLvl;
  logic raw;
  logic rise;
  logic fall;

  always_comb begin
    state_d = state_q;
    unique case (ctrl[acmp_pkg::CH_HI:acmp_pkg::CH_LO])
      acmp_pkg::CH_B: minusLvl = pinB;
      acmp_pkg::CH_C: minusLvl = pinC;
      acmp_pkg::CH_D: minusLvl = pinD;
      acmp_pkg::CH_FIXED: minusLvl = fixedRef;
    endcase
    plusLvl = ctrl[acmp_pkg::REF_BIT] ? ladderRef : pinA;
    // A switched-off comparator parks its raw decision high, matching the reset status.
    raw = ctrl[acmp_pkg::ON_BIT] ? (plusLvl > minusLvl) : 1'b1;
    state_d.cout = raw ^ ctrl[acmp_pkg::POL_BIT];
    rise = state_d.cout & ~state_q.cout;
    fall = ~state_d.cout & state_q.cout;
    unique case (ctrl[acmp_pkg::EDGE_HI:acmp_pkg::EDGE_LO])
      acmp_pkg::EDGE_NONE: state_d.evt = 1'b0;
      acmp_pkg::EDGE_RISE: state_d.evt = rise;
      acmp_pkg::EDGE_FALL: state_d.evt = fall;
      acmp_pkg::EDGE_ANY: state_d.evt = rise | fall;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= '{cout: acmp_pkg::STATUS_RESET, evt: 1'b0};
    end else begin
      state_q <= state_d;
    end
  end

  assign coutQ = state_q.cout;
  assign evtQ = state_q.evt;

  AST_OFF_PARKED: assert property (@(posedge clk) disable iff (!rst_b)
    !ctrl[acmp_pkg::ON_BIT] && !ctrl[acmp_pkg::POL_BIT] |=> coutQ)
    else $error("disabled comparator output not parked high");

  AST_PIN_COMPARE: assert property (@(posedge clk) disable iff (!rst_b)
    ctrl[7:5] == 3'h4 && ctrl[2:0] == 3'h0 |=> coutQ == $past(pinA > pinB))
    else $error("pin A against pin B decision wrong");

  AST_LADDER_FIXED: assert property (@(posedge clk) disable iff (!rst_b)
    ctrl[7:5] == 3'h5 && ctrl[2:0] == 3'h7 |=> coutQ == $past(ladderRef <= fixedRef))
    else $error("inverted ladder against fixed reference decision wrong");

  AST_RISE_EVENT: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(coutQ) && $past(ctrl[4:3]) == acmp_pkg::EDGE_RISE |-> evtQ)
    else $error("rising edge missed");

  AST_FALL_QUIET: assert property (@(posedge clk) disable iff (!rst_b)
    $fell(coutQ) && $past(ctrl[4:3]) == acmp_pkg::EDGE_RISE |-> !evtQ)
    else $error("falling edge flagged in rising mode");

endmodule // cmp_channel

// [src/analog_comparator_control.sv]
// Control and status logic of three analog comparators behind an AHB-Lite slave.
// Assumes analog levels are presented as unsigned codes synchronous to clk.
//
// The register offsets and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ns
module analog_comparator_control #(
  parameter int W = 10,
  parameter logic [W-1:0] FIXED_REF = 10'h07b
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Analog levels per comparator, and the ladder level shared by all three.
  input wire logic [2:0][W-1:0] pinA,
  input wire logic [2:0][W-1:0] pinB,
  input wire logic [2:0][W-1:0] pinC,
  input wire logic [2:0][W-1:0] pinD,
  input wire logic [W-1:0] ladderRef,
  // Remappable pin outputs.
  output logic [2:0] pinOut,
  output logic [2:0] pinOutEn,
  // Interrupt request.
  output logic irqReq
);

  typedef struct packed {
    logic dataPhase;
    logic dataWrite;
    logic [7:0] dataAddr;
    logic [31:0] rdata;
    logic [2:0][7:0] ctrl;
    logic [2:0] flag;
    logic [2:0] flagEn;
    logic periphEn;
    logic globalEn;
  } regs_s;

  regs_s state_q;
  regs_s state_d;
  logic [2:0] coutQ;
  logic [2:0] evtQ;
  logic addrPhase;
  logic wrFlag2;
  logic wrFlag5;
  logic wrEna2;
  logic wrEna5;
  logic wrIntCtl;
  logic [2:0] wrCtrl;

  function automatic logic [7:0] ctrlOff(input int i);
    ctrlOff = acmp_pkg::OFF_CTRL1 + 8'(4 * i);
  endfunction

  function automatic logic hitWrite(input regs_s s, input logic [7:0] off);
    hitWrite = s.dataPhase && s.dataWrite && s.dataAddr == off;
  endfunction

  function automatic logic [31:0] readReg(input regs_s s, input logic [7:0] a, input logic [2:0] cout);
    readReg = 32'h0000_0000;
    for (int i = 0; i < 3; i++) begin
      if (a == ctrlOff(i)) begin
        readReg[7:0] = s.ctrl[i];
      end
    end
    unique case (a)
      acmp_pkg::OFF_STATUS: readReg[2:0] = cout;
      acmp_pkg::OFF_FLAG2: begin
        readReg[acmp_pkg::CMP1_IRQ_BIT] = s.flag[0];
        readReg[acmp_pkg::CMP2_IRQ_BIT] = s.flag[1];
      end
      acmp_pkg::OFF_FLAG5: readReg[acmp_pkg::CMP3_IRQ_BIT] = s.flag[2];
      acmp_pkg::OFF_ENA2: begin
        readReg[acmp_pkg::CMP1_IRQ_BIT] = s.flagEn[0];
        readReg[acmp_pkg::CMP2_IRQ_BIT] = s.flagEn[1];
      end
      acmp_pkg::OFF_ENA5: readReg[acmp_pkg::CMP3_IRQ_BIT] = s.flagEn[2];
      acmp_pkg::OFF_INTCTL: begin
        readReg[acmp_pkg::PERIPH_EN_BIT] = s.periphEn;
        readReg[acmp_pkg::GLOBAL_EN_BIT] = s.globalEn;
      end
      default: readReg[31:8] = 24'h00_0000;
    endcase
  endfunction

  // Each comparator runs on its own control byte and edge detector.
  for (genvar g = 0; g < 3; g++) begin : gCh
    cmp_channel #(.W(W)) uChannel (
      .clk(clk),
      .rst_b(rst_b),
      .ctrl(state_q.ctrl[g]),
      .pinA(pinA[g]),
      .pinB(pinB[g]),
      .pinC(pinC[g]),
      .pinD(pinD[g]),
      .ladderRef(ladderRef),
      .fixedRef(FIXED_REF),
      .coutQ(coutQ[g]),
      .evtQ(evtQ[g])
    );
  end

  assign addrPhase = hsel && hready && htrans[1];
  assign wrFlag2 = hitWrite(state_q, acmp_pkg::OFF_FLAG2);
  assign wrFlag5 = hitWrite(state_q, acmp_pkg::OFF_FLAG5);
  assign wrEna2 = hitWrite(state_q, acmp_pkg::OFF_ENA2);
  assign wrEna5 = hitWrite(state_q, acmp_pkg::OFF_ENA5);
  assign wrIntCtl = hitWrite(state_q, acmp_pkg::OFF_INTCTL);

  always_comb begin
    state_d = state_q;
    for (int i = 0; i < 3; i++) begin
      wrCtrl[i] = hitWrite(state_q, ctrlOff(i));
    end
    state_d.dataPhase = addrPhase;
    state_d.dataWrite = addrPhase && hwrite;
    state_d.dataAddr = addrPhase ? haddr[7:0] : state_q.dataAddr;
    // Software writes land first, so a hardware event in the same cycle wins over a clear.
    if (wrFlag2) begin
      state_d.flag[0] = hwdata[acmp_pkg::CMP1_IRQ_BIT];
      state_d.flag[1] = hwdata[acmp_pkg::CMP2_IRQ_BIT];
    end
    if (wrFlag5) begin
      state_d.flag[2] = hwdata[acmp_pkg::CMP3_IRQ_BIT];
    end
    if (wrEna2) begin
      state_d.flagEn[0] = hwdata[acmp_pkg::CMP1_IRQ_BIT];
      state_d.flagEn[1] = hwdata[acmp_pkg::CMP2_IRQ_BIT];
    end
    if (wrEna5) begin
      state_d.flagEn[2] = hwdata[acmp_pkg::CMP3_IRQ_BIT];
    end
    if (wrIntCtl) begin
      state_d.periphEn = hwdata[acmp_pkg::PERIPH_EN_BIT];
      state_d.globalEn = hwdata[acmp_pkg::GLOBAL_EN_BIT];
    end
    for (int i = 0; i < 3; i++) begin
      if (wrCtrl[i]) begin
        state_d.ctrl[i] = hwdata[7:0];
        if (hwdata[acmp_pkg::EDGE_HI:acmp_pkg::EDGE_LO] == acmp_pkg::EDGE_ANY) begin
          state_d.flag[i] = 1'b1;
        end
      end
      if (evtQ[i]) begin
        state_d.flag[i] = 1'b1;
      end
    end
    // Reads see the writes of the previous data phase, so write-then-read is coherent.
    if (addrPhase && !hwrite) begin
      state_d.rdata = readReg(state_d, haddr[7:0], coutQ);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= '0;
      state_q.ctrl <= {3{acmp_pkg::CTRL_RESET}};
    end else begin
      state_q <= state_d;
    end
  end

  // The slave never stalls and never errors.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = state_q.rdata;

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      pinOutEn[i] = state_q.ctrl[i][acmp_pkg::OE_BIT];
      pinOut[i] = pinOutEn[i] & coutQ[i];
    end
  end

  // The flag is set regardless; only the request is gated.
  assign irqReq = |(state_q.flag & state_q.flagEn) && state_q.periphEn && state_q.globalEn;

  sequence sWriteAnyMode;
    wrCtrl[0] && hwdata[4:3] == 2'h3;
  endsequence

  sequence sFlagHeld;
    state_q.flag[0] ##1 state_q.flag[0];
  endsequence

  AST_ANY_MODE_SETS: assert property (@(posedge clk) disable iff (!rst_b)
    sWriteAnyMode |=> state_q.flag[0])
    else $error("selecting any-change mode did not set the flag");

  AST_EVENT_SETS_FLAG: assert property (@(posedge clk) disable iff (!rst_b)
    evtQ[1] |=> state_q.flag[1])
    else $error("edge event lost, including against a clear");

  AST_FLAG_STICKY: assert property (@(posedge clk) disable iff (!rst_b)
    state_q.flag[0] && !wrFlag2 |=> state_q.flag[0])
    else $error("flag dropped without a software clear");

  AST_SOFT_SET: assert property (@(posedge clk) disable iff (!rst_b)
    wrFlag5 && hwdata[5] |=> state_q.flag[2])
    else $error("software write of one did not set the flag");

  AST_CLEAR_WORKS: assert property (@(posedge clk) disable iff (!rst_b)
    wrFlag2 && !hwdata[6] && !evtQ[1] |=> !state_q.flag[1])
    else $error("software clear ignored");

  AST_IRQ_GATED: assert property (@(posedge clk) disable iff (!rst_b)
    evtQ[0] && !state_q.globalEn && !wrIntCtl |=> state_q.flag[0] && !irqReq)
    else $error("flag not set or request raised while global enable is off");

  AST_IRQ_RAISED: assert property (@(posedge clk) disable iff (!rst_b)
    sFlagHeld ##0 (state_q.flagEn[0] && state_q.periphEn && state_q.globalEn) |-> irqReq)
    else $error("enabled flag did not raise the request");

  AST_STATUS_READ: assert property (@(posedge clk) disable iff (!rst_b)
    addrPhase && !hwrite && haddr[7:0] == 8'h0c |=> hrdata == {29'h0, $past(coutQ)})
    else $error("status read does not return comparator outputs");

  AST_PIN_ROUTE: assert property (@(posedge clk) disable iff (!rst_b)
    !state_q.ctrl[2][6] |-> !pinOut[2] && !pinOutEn[2])
    else $error("output reached the pin while routing is off");

  // Each comparator is checked by index, so a slip in one channel's wiring shows up on its own.
  sequence sSoftSetCmp1;
    wrFlag2 && hwdata[acmp_pkg::CMP1_IRQ_BIT];
  endsequence

  sequence sCtrlRead1;
    addrPhase && !hwrite && haddr[7:0] == acmp_pkg::OFF_CTRL1;
  endsequence

  sequence sCmp2Armed;
    state_q.flagEn[1] && state_q.periphEn && state_q.globalEn;
  endsequence

  AST_SOFT_SET_CMP1: assert property (@(posedge clk) disable iff (!rst_b)
    sSoftSetCmp1 |=> state_q.flag[0])
    else $error("software write of one did not set the first flag");

  AST_SOFT_SET_CMP2: assert property (@(posedge clk) disable iff (!rst_b)
    wrFlag2 && hwdata[acmp_pkg::CMP2_IRQ_BIT] |=> state_q.flag[1])
    else $error("software write of one did not set the second flag");

  AST_EVENT_CMP1: assert property (@(posedge clk) disable iff (!rst_b)
    evtQ[0] |=> state_q.flag[0])
    else $error("first comparator event lost");

  AST_EVENT_CMP3: assert property (@(posedge clk) disable iff (!rst_b)
    evtQ[2] |=> state_q.flag[2])
    else $error("third comparator event lost");

  AST_STICKY_CMP2: assert property (@(posedge clk) disable iff (!rst_b)
    state_q.flag[1] && !wrFlag2 |=> state_q.flag[1])
    else $error("second flag dropped without a software clear");

  AST_STICKY_CMP3: assert property (@(posedge clk) disable iff (!rst_b)
    state_q.flag[2] && !wrFlag5 |=> state_q.flag[2])
    else $error("third flag dropped without a software clear");

  AST_CLEAR_CMP3: assert property (@(posedge clk) disable iff (!rst_b)
    wrFlag5 && !hwdata[acmp_pkg::CMP3_IRQ_BIT] && !evtQ[2] |=> !state_q.flag[2])
    else $error("third flag clear ignored");

  AST_NO_SPURIOUS_FLAG: assert property (@(posedge clk) disable iff (!rst_b)
    !state_q.flag[0] && !evtQ[0] && !wrFlag2 && !wrCtrl[0] |=> !state_q.flag[0])
    else $error("first flag set without an event or a write");

  AST_CTRL_WRITE: assert property (@(posedge clk) disable iff (!rst_b)
    wrCtrl[1] |=> state_q.ctrl[1] == $past(hwdata[7:0]))
    else $error("second control write did not land");

  AST_CTRL_KEEP: assert property (@(posedge clk) disable iff (!rst_b)
    !wrCtrl[2] |=> $stable(state_q.ctrl[2]))
    else $error("third control changed without its own write");

  AST_CTRL_READ: assert property (@(posedge clk) disable iff (!rst_b)
    sCtrlRead1 ##0 !wrCtrl[0] |=> hrdata == {24'h00_0000, $past(state_q.ctrl[0])})
    else $error("first control read returned a wrong value");

  AST_ENA_WRITE: assert property (@(posedge clk) disable iff (!rst_b)
    wrEna2 |=> state_q.flagEn[1:0] == $past(hwdata[6:5]))
    else $error("flag enable write did not land");

  AST_INTCTL_WRITE: assert property (@(posedge clk) disable iff (!rst_b)
    wrIntCtl |=> {state_q.globalEn, state_q.periphEn} == $past(hwdata[7:6]))
    else $error("interrupt control write did not land");

  AST_IRQ_OFF: assert property (@(posedge clk) disable iff (!rst_b)
    !state_q.periphEn || !state_q.globalEn |-> !irqReq)
    else $error("request raised with an upper enable clear");

  AST_ROUTE_ON: assert property (@(posedge clk) disable iff (!rst_b)
    state_q.ctrl[0][acmp_pkg::OE_BIT] |-> pinOutEn[0] && pinOut[0] == coutQ[0])
    else $error("routed pin does not follow the first comparator");

  AST_IRQ_FOLLOWS_EVENT: assert property (@(posedge clk) disable iff (!rst_b)
    evtQ[1] && !wrEna2 && !wrIntCtl ##0 sCmp2Armed |=> irqReq)
    else $error("enabled second comparator event raised no request");

  AST_RDATA_HOLDS: assert property (@(posedge clk) disable iff (!rst_b)
    !(addrPhase && !hwrite) |=> $stable(hrdata))
    else $error("read data changed without a read");

endmodule // analog_comparator_control

// [test/analog_src.sv]
// Partner model: the analog level codes seen by the three comparators.
// Assumes the bench calls put from its own thread; levels move only right after a rising clock edge.
`timescale 1ns/1ns
module analog_src #(
  parameter int W = 10
) (
  // Clock.
  input wire logic clk,
  // Levels.
  output logic [2:0][W-1:0] pinA,
  output logic [2:0][W-1:0] pinB,
  output logic [2:0][W-1:0] pinC,
  output logic [2:0][W-1:0] pinD,
  output logic [W-1:0] ladderRef
);
  initial begin
    pinA = '0;
    pinB = '0;
    pinC = '0;
    pinD = '0;
    ladderRef = '0;
  end

  // Every pin source and the ladder are driven as settled analog levels, as software must set them up; the fixed reference is a parameter.
  task automatic put(input int k, input logic [W-1:0] a, b, c, d, r);
    @(posedge clk);
    pinA[k] <= a;
    pinB[k] <= b;
    pinC[k] <= c;
    pinD[k] <= d;
    ladderRef <= r;
  endtask
endmodule // analog_src

// [test/tb_analog_comparator_control.sv]
// Self-checking bench of the comparator control block over its AHB-Lite port.
// Assumes the package offsets and a zero-wait slave whose hreadyout feeds hready.
`timescale 1ns/1ns
module tb_analog_comparator_control;
  logic clk = 1'b0;
  logic rstB;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic [2:0][9:0] pinA, pinB, pinC, pinD;
  logic [9:0] ladderRef;
  logic [2:0] pinOut, pinOutEn;
  logic irqReq;
  int errorCnt = 0;
  int nTests = 0;

  always #10 clk = ~clk;

  analog_comparator_control dut_u (.clk(clk), .rst_b(rstB), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .pinA(pinA), .pinB(pinB), .pinC(pinC), .pinD(pinD),
    .ladderRef(ladderRef), .pinOut(pinOut), .pinOutEn(pinOutEn), .irqReq(irqReq));

  analog_src src_u (.clk(clk), .pinA(pinA), .pinB(pinB), .pinC(pinC), .pinD(pinD), .ladderRef(ladderRef));

  task automatic testDone;
    $display("Comparisons %0d, mismatches %0d", nTests, errorCnt);
    if (errorCnt == 0 && nTests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    nTests++;
    if (got !== exp) begin
      errorCnt++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic busXfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  task automatic busWr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    busXfer(1'b1, a, d, q);
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string w);
    logic [31:0] q;
    busXfer(1'b0, a, 32'h0, q);
    chk(q & m, e, w);
    chk({31'h0, hresp}, 32'h0, "bus response");
  endtask

  task automatic tReset;
    for (int k = 0; k < 3; k++) begin
      rdChk(acmp_pkg::OFF_CTRL1 + 8'(4 * k), 32'hffffffff, 32'h1f, "control after reset");
    end
    rdChk(acmp_pkg::OFF_STATUS, 32'hffffffff, 32'h7, "status after reset");
    rdChk(acmp_pkg::OFF_FLAG2, 32'hffffffff, 32'h0, "flags after reset");
    rdChk(8'h40, 32'hffffffff, 32'h0, "unmapped read");
    chk({31'h0, irqReq}, 32'h0, "request after reset");
  endtask

  task automatic tInputs;
    // Only the selected inverting source sits above pin A; the fixed reference is below it.
    for (int ch = 0; ch < 4; ch++) begin
      src_u.put(0, 10'h150, ch == 0 ? 10'h200 : 10'h0, ch == 1 ? 10'h200 : 10'h0, ch == 2 ? 10'h200 : 10'h0, 10'h0);
      busWr(acmp_pkg::OFF_CTRL1, {24'h0, 8'h80 | 8'(ch)});
      repeat (4) @(posedge clk);
      rdChk(acmp_pkg::OFF_STATUS, 32'h1, 32'(ch == 3), "inverting select");
    end
    src_u.put(0, 10'h150, 10'h200, 10'h0, 10'h0, 10'h300);
    busWr(acmp_pkg::OFF_CTRL1, 32'h84);
    repeat (4) @(posedge clk);
    rdChk(acmp_pkg::OFF_STATUS, 32'h1, 32'h1, "ladder on plus input");
    busWr(acmp_pkg::OFF_CTRL1, 32'ha7);
    repeat (4) @(posedge clk);
    rdChk(acmp_pkg::OFF_STATUS, 32'h1, 32'h0, "inverted ladder above fixed");
    src_u.put(0, 10'h150, 10'h200, 10'h0, 10'h0, 10'h0);
    repeat (4) @(posedge clk);
    rdChk(acmp_pkg::OFF_STATUS, 32'h1, 32'h1, "inverted ladder below fixed");
    busWr(acmp_pkg::OFF_CTRL1, 32'h80);
    repeat (4) @(posedge clk);
    rdChk(acmp_pkg::OFF_STATUS, 32'h1, 32'h0, "pin A on plus input");
    busWr(acmp_pkg::OFF_CTRL1, 32'h00);
    busWr(acmp_pkg::OFF_STATUS, 32'h0);
    repeat (4) @(posedge clk);
    rdChk(acmp_pkg::OFF_STATUS, 32'hff, 32'h7, "off and status write");
  endtask

  task automatic tPolarity;
    busWr(acmp_pkg::OFF_CTRL1, 32'he0);
    repeat (4) @(posedge clk);
    rdChk(acmp_pkg::OFF_STATUS, 32'h1, 32'h1, "inverted output");
    chk({29'h0, pinOut}, 32'h1, "routed pin");
    chk({29'h0, pinOutEn}, 32'h1, "routed enable");
    busWr(acmp_pkg::OFF_CTRL1, 32'h80);
    repeat (4) @(posedge clk);
    chk({26'h0, pinOutEn, pinOut}, 32'h0, "internal only");
  endtask

  task automatic tEdge;
    // Entry: expected flag, invert, edge select, plus input rising.
    logic [4:0] tbl [8] = '{5'b10011, 5'b00010, 5'b10100, 5'b00101, 5'b11010, 5'b11101, 5'b00001, 5'b10110};
    logic [4:0] e;
    for (int i = 0; i < 8; i++) begin
      e = tbl[i];
      src_u.put(0, e[0] ? 10'h100 : 10'h300, 10'h200, 10'h0, 10'h0, 10'h0);
      busWr(acmp_pkg::OFF_CTRL1, {24'h0, 2'b10, e[3:1], 3'b000});
      repeat (4) @(posedge clk);
      busWr(acmp_pkg::OFF_FLAG2, 32'h0);
      src_u.put(0, e[0] ? 10'h300 : 10'h100, 10'h200, 10'h0, 10'h0, 10'h0);
      repeat (4) @(posedge clk);
      rdChk(acmp_pkg::OFF_FLAG2, 32'h20, e[4] ? 32'h20 : 32'h0, "edge flag");
      repeat (8) @(posedge clk);
      rdChk(acmp_pkg::OFF_FLAG2, 32'h20, e[4] ? 32'h20 : 32'h0, "flag held");
    end
  endtask

  task automatic tIrq;
    busWr(acmp_pkg::OFF_ENA2, 32'h20);
    busWr(acmp_pkg::OFF_INTCTL, 32'h40);
    @(posedge clk);
    chk({31'h0, irqReq}, 32'h0, "global enable clear");
    busWr(acmp_pkg::OFF_INTCTL, 32'hc0);
    @(posedge clk);
    chk({31'h0, irqReq}, 32'h1, "all enables set");
    busWr(acmp_pkg::OFF_ENA2, 32'h0);
    @(posedge clk);
    chk({31'h0, irqReq}, 32'h0, "flag enable clear");
    busWr(acmp_pkg::OFF_FLAG2, 32'h60);
    rdChk(acmp_pkg::OFF_FLAG2, 32'hff, 32'h60, "software set");
    busWr(acmp_pkg::OFF_FLAG5, 32'h20);
    rdChk(acmp_pkg::OFF_FLAG5, 32'hff, 32'h20, "software set third");
    busWr(acmp_pkg::OFF_FLAG5, 32'h0);
    rdChk(acmp_pkg::OFF_FLAG5, 32'hff, 32'h0, "software clear third");
    busWr(acmp_pkg::OFF_CTRL3, 32'h18);
    repeat (4) @(posedge clk);
    rdChk(acmp_pkg::OFF_FLAG5, 32'hff, 32'h20, "any-change select");
    busWr(acmp_pkg::OFF_ENA5, 32'h20);
    @(posedge clk);
    chk({31'h0, irqReq}, 32'h1, "third flag request");
    busWr(acmp_pkg::OFF_FLAG2, 32'h0);
    rdChk(acmp_pkg::OFF_FLAG2, 32'hff, 32'h0, "software clear");
  endtask

  task automatic tCmp2;
    logic [31:0] prevSt;
    logic [31:0] curSt;
    busWr(acmp_pkg::OFF_FLAG5, 32'h0);
    busWr(acmp_pkg::OFF_ENA2, 32'h40);
    src_u.put(1, 10'h100, 10'h200, 10'h0, 10'h0, 10'h0);
    busWr(acmp_pkg::OFF_CTRL2, 32'h88);
    repeat (4) @(posedge clk);
    busWr(acmp_pkg::OFF_FLAG2, 32'h0);
    chk({31'h0, irqReq}, 32'h0, "second comparator idle");
    src_u.put(1, 10'h300, 10'h200, 10'h0, 10'h0, 10'h0);
    repeat (4) @(posedge clk);
    rdChk(acmp_pkg::OFF_FLAG2, 32'h60, 32'h40, "second comparator edge alone");
    chk({31'h0, irqReq}, 32'h1, "second comparator request");
    // Software keeps the last status itself; the any-change flag alone cannot tell the direction.
    busXfer(1'b0, acmp_pkg::OFF_STATUS, 32'h0, prevSt);
    busWr(acmp_pkg::OFF_FLAG2, 32'h0);
    src_u.put(0, 10'h300, 10'h200, 10'h0, 10'h0, 10'h0);
    repeat (4) @(posedge clk);
    rdChk(acmp_pkg::OFF_FLAG2, 32'h20, 32'h20, "any-change flag");
    busXfer(1'b0, acmp_pkg::OFF_STATUS, 32'h0, curSt);
    chk({31'h0, curSt[0] & ~prevSt[0]}, 32'h1, "rise told by kept status");
  endtask

  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    rstB = 1'b0;
    repeat (5) @(posedge clk);
    rstB <= 1'b1;
    tReset;
    tInputs;
    tPolarity;
    tEdge;
    tIrq;
    tCmp2;
    testDone;
  end

  // The whole sequence needs well under two thousand cycles.
  initial begin
    repeat (6000) @(posedge clk);
    errorCnt++;
    testDone;
  end
endmodule // tb_analog_comparator_control
